//--- rtl/expander_defines.svh
// offsets, field positions and reset values of the change-detect register block
`ifndef EXPANDER_DEFINES_SVH
`define EXPANDER_DEFINES_SVH

`define CFG_ADDR        8'h04
`define MASK_ADDR       8'h06
`define CFG_SHDN_BIT    0
`define CFG_DETECT_BIT  7
`define MASK_INT_BIT    7
`define CFG_RESET       8'h00
`define MASK_RESET      7'h00
`define CHG_PORTS       7
`define SYNC_STAGES     2

`endif

//--- rtl/expander_pkg.sv
// types shared by the change-detect register block
package expander_pkg;

    // one register access from the serial front end, valid for one cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;

    // registered read answer
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_t;

endpackage : expander_pkg

//--- rtl/pin_sync.sv
// two-stage synchroniser bank for the change-detecting port pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage is read only by the second stage, per bit
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_ff[i] <= 1'b0;
                sync_ff[i] <= 1'b0;
            end else begin
                meta_ff[i] <= din[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end

    assign dout = sync_ff;

endmodule : pin_sync

//--- rtl/change_detect_regs.sv
// configuration and change-detect mask registers with the change interrupt flag
`timescale 1ns/1ps
`include "expander_defines.svh"

// How it works
// - config register at 0x04: D7 detect enable, D6 zero, D5..D1 unused
// - config bit D0: zero means shutdown, one means normal operation
// - config bit D7 gates change detection: zero off, one on
// - mask write at 0x06 stores D0..D6 as port 24..30 masks, D7 ignored
// - mask read returns interrupt flag in D7, flag clears after the read unless a change arrives in the same cycle
// - mask read returns port 24..30 bits in D0..D6, ascending
// - after reset config reads shutdown, detection off, all zero
// - after reset all port mask bits are cleared
// - unused bits always read zero whatever was written
module change_detect_regs #(
    parameter int NPORTS = `CHG_PORTS
) (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire expander_pkg::reg_req_t REQ,
    output expander_pkg::reg_rsp_t      RSP,
    input  wire logic [NPORTS-1:0]     PORT_IN,
    output logic                       INT_OUT,
    output logic                       NORMAL_OP,
    output logic                       DETECT_EN
);
    import expander_pkg::*;

    // the mask register has exactly seven port bits below the flag bit
    if (NPORTS != `CHG_PORTS) begin : g_check
        $error("change_detect_regs supports exactly seven change-detecting ports");
    end

    // ********************************
    // pin sampling
    // ********************************
    logic [NPORTS-1:0] port_sync;
    logic [NPORTS-1:0] port_prev_ff;
    logic [NPORTS-1:0] port_change;

    pin_sync #(
        .WIDTH (NPORTS)
    ) u_sync (
        .clk  (CLK),
        .rst  (RST),
        .din  (PORT_IN),
        .dout (port_sync)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            port_prev_ff <= '0;
        end else begin
            port_prev_ff <= port_sync;
        end
    end

    assign port_change = port_sync ^ port_prev_ff;

    // ********************************
    // register decode
    // ********************************
    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction : hit

    logic       cfg_wr;
    logic       mask_wr;
    logic       mask_rd;
    logic       detect_ff;
    logic       normal_ff;
    logic [NPORTS-1:0] mask_ff;
    logic       int_ff;
    logic       int_event;
    logic [7:0] cfg_view;
    logic [7:0] mask_view;
    logic [7:0] nxt_rdata;
    reg_rsp_t   rsp_ff;

    assign cfg_wr  = REQ.wr && hit(REQ, `CFG_ADDR);
    assign mask_wr = REQ.wr && hit(REQ, `MASK_ADDR);
    assign mask_rd = REQ.rd && hit(REQ, `MASK_ADDR);

    // ********************************
    // configuration register
    // ********************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            detect_ff <= 1'(`CFG_RESET >> `CFG_DETECT_BIT);
            normal_ff <= 1'(`CFG_RESET >> `CFG_SHDN_BIT);
        end else if (cfg_wr) begin
            detect_ff <= REQ.data[`CFG_DETECT_BIT];
            normal_ff <= REQ.data[`CFG_SHDN_BIT];
        end
    end

    // D6 and D5..D1 are not stored at all, so they can only read as zero
    assign cfg_view = {detect_ff, 6'h00, normal_ff};

    // ********************************
    // mask register and change flag
    // ********************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            mask_ff <= `MASK_RESET;
        end else if (mask_wr) begin
            mask_ff <= REQ.data[NPORTS-1:0];
        end
    end

    assign int_event = detect_ff && |(port_change & mask_ff);

    // a change in the same cycle as the clearing read wins, so it is never lost
    always_ff @(posedge CLK) begin
        if (RST) begin
            int_ff <= 1'b0;
        end else if (int_event) begin
            int_ff <= 1'b1;
        end else if (mask_rd) begin
            int_ff <= 1'b0;
        end
    end

    assign mask_view = {int_ff, mask_ff};

    // ********************************
    // read answer
    // ********************************
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit(REQ, `CFG_ADDR)) begin
            nxt_rdata = cfg_view;
        end else if (hit(REQ, `MASK_ADDR)) begin
            nxt_rdata = mask_view;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid <= REQ.rd;
            if (REQ.rd) begin
                rsp_ff.data <= nxt_rdata;
            end
        end
    end

    assign RSP       = rsp_ff;
    assign INT_OUT   = int_ff;
    assign NORMAL_OP = normal_ff;
    assign DETECT_EN = detect_ff;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    cfg_after_reset_a: assert property (
        $fell(RST) |-> !NORMAL_OP && !DETECT_EN)
        else $error("config not cleared after reset");

    mask_after_reset_a: assert property (
        $fell(RST) |-> mask_ff == 7'h00)
        else $error("mask not cleared after reset");

    power_bit_a: assert property (
        cfg_wr |=> NORMAL_OP == $past(REQ.data[0]) && DETECT_EN == $past(REQ.data[7]))
        else $error("config write not reflected");

    int_set_a: assert property (
        DETECT_EN && |(port_change & mask_ff) |=> INT_OUT ##1 (INT_OUT || $past(mask_rd)))
        else $error("change did not raise interrupt");

    int_clear_a: assert property (
        mask_rd && !int_event |=> !INT_OUT)
        else $error("interrupt not cleared by read");

    mask_readback_a: assert property (
        mask_rd |=> RSP.valid && RSP.data == {$past(int_ff), $past(mask_ff)})
        else $error("mask read data wrong");

    flag_unchanged_a: assert property (
        mask_wr && !int_event && !mask_rd |=> INT_OUT == $past(INT_OUT))
        else $error("mask write disturbed flag");

    unused_zero_a: assert property (
        REQ.rd && hit(REQ, `CFG_ADDR) |=> RSP.data[6:1] == 6'h00)
        else $error("unused config bits not zero");

    detect_off_a: assert property (
        !DETECT_EN && !INT_OUT |=> !INT_OUT)
        else $error("interrupt raised while detection off");

    read_answer_a: assert property (
        REQ.rd |=> RSP.valid)
        else $error("read answer missing");

    spurious_answer_a: assert property (
        !REQ.rd |=> !RSP.valid)
        else $error("read answer without a read");

    cfg_readback_a: assert property (
        REQ.rd && hit(REQ, `CFG_ADDR) |=> RSP.data[7] == $past(DETECT_EN) && RSP.data[0] == $past(NORMAL_OP))
        else $error("config read data wrong");

    unmapped_zero_a: assert property (
        REQ.rd && !hit(REQ, `CFG_ADDR) && !hit(REQ, `MASK_ADDR) |=> RSP.data == 8'h00)
        else $error("unmapped read not zero");

    mask_store_a: assert property (
        mask_wr |=> mask_ff == $past(REQ.data[6:0]))
        else $error("mask write not stored");

    int_hold_a: assert property (
        INT_OUT && !mask_rd |=> INT_OUT)
        else $error("interrupt dropped without a read");

    int_raise_c: cover property (DETECT_EN ##1 $rose(INT_OUT));
    int_read_c:  cover property (INT_OUT && mask_rd ##1 !INT_OUT);
    set_wins_c:  cover property (mask_rd && int_event ##1 INT_OUT);
    cfg_write_c: cover property (cfg_wr ##1 NORMAL_OP);
    unmapped_c:  cover property (REQ.rd && !hit(REQ, `CFG_ADDR) && !hit(REQ, `MASK_ADDR));

endmodule : change_detect_regs

//--- tb/pin_model.sv
// pin driver for the change-detecting ports, paced by its own link clock
`timescale 1ns/1ps
module pin_model (
    input  wire logic [6:0] want,
    output logic      [6:0] pins
);
    logic lclk = 1'b0;
    // pins move only on link clock edges, which always fall on device clock falling edges
    initial forever #200 lclk = ~lclk;
    initial pins = 7'h00;
    always @(posedge lclk) pins <= want;
endmodule : pin_model

//--- tb/tb_top.sv
// self-checking bench for the change-detect register block
`timescale 1ns/1ps
module tb_top;
    import expander_pkg::*;
    logic       CLK = 1'b0;
    logic       RST = 1'b1;
    reg_req_t   req = '0;
    reg_rsp_t   rsp;
    logic [6:0] want = 7'h00;
    logic [6:0] pins;
    logic       int_out;
    logic       normal_op;
    logic       detect_en;
    logic [7:0] expq[$];
    logic [7:0] m;
    int         miscompares = 0;
    int         n_compared = 0;
    int         cycles = 0;
    integer     seed = 32'h800555e9;

    change_detect_regs u_change_detect_regs (.CLK(CLK), .RST(RST), .REQ(req), .RSP(rsp),
        .PORT_IN(pins), .INT_OUT(int_out), .NORMAL_OP(normal_op), .DETECT_EN(detect_en));
    pin_model u_pin_model (.want(want), .pins(pins));

    // ****************************************
    // compare and bus tasks
    // ****************************************
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8
    task automatic cmp1(input string what, input logic exp, input logic got);
        cmp8(what, {7'h00, exp}, {7'h00, got});
    endtask : cmp1
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        #1 req = '{wr: w, rd: r, addr: a, data: d};
        @(posedge CLK);
        #1 req = '0;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr
    // the expected byte is noted before the strobe so the watcher never runs ahead
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        expq.push_back(exp);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    // bounded wait: a missing flag shows up as a mismatch, not a hang
    task automatic wait_int(input logic exp);
        int i;
        // look just after each edge so the flag is settled when read
        for (i = 0; i < 30 && int_out !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        cmp1("int_out", exp, int_out);
    endtask : wait_int
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // clock, watcher, timeout, sequence
    // ****************************************
    initial forever #25 CLK = ~CLK;
    always @(negedge CLK) begin
        if (rsp.valid === 1'b1) begin
            cmp8("rdata", expq.size() > 0 ? expq.pop_front() : 8'hxx, rsp.data);
        end
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge CLK);
        #1 RST = 1'b0;
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h00);
        wr(8'h04, 8'hff);
        cmp1("normal_op", 1'b1, normal_op);
        cmp1("detect_en", 1'b1, detect_en);
        rd(8'h04, 8'h81);
        wr(8'h04, 8'h7e);
        cmp1("normal_op", 1'b0, normal_op);
        rd(8'h04, 8'h00);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h7f);
        m = 8'($random(seed));
        wr(8'h06, m);
        rd(8'h06, {1'b0, m[6:0]});
        rd(8'h05, 8'h00);
        wr(8'h06, 8'h01);
        want = 7'h01;
        wait_int(1'b0);
        wr(8'h04, 8'h80);
        want = 7'h03;
        wait_int(1'b0);
        want = 7'h02;
        wait_int(1'b1);
        rd(8'h06, 8'h81);
        cmp1("int_out", 1'b0, int_out);
        rd(8'h06, 8'h01);
        wr(8'h04, 8'h81);
        want = 7'h03;
        wait_int(1'b1);
        // reset again in mid-run with state set: everything must come back cleared
        @(posedge CLK);
        #1 RST = 1'b1;
        repeat (3) @(posedge CLK);
        #1 RST = 1'b0;
        cmp1("int_out", 1'b0, int_out);
        cmp1("normal_op", 1'b0, normal_op);
        cmp1("detect_en", 1'b0, detect_en);
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h00);
        // every noted read must have been answered
        repeat (2) @(posedge CLK);
        #1 cmp8("reads_pending", 8'h00, 8'(expq.size()));
        finish_test();
    end
endmodule : tb_top
